// ===== common/dtf_pkg.sv
// Shared constants and types for the trace FIFO readout and run control
package dtf_pkg;

	localparam int              FIFO_DEPTH    = 8;
	localparam int              WORD_W        = 16;

	// Register selects on the device's own port
	localparam logic [1:0]      SEL_FIFO_HIGH = 2'h0;
	localparam logic [1:0]      SEL_FIFO_LOW  = 2'h1;
	localparam logic [1:0]      SEL_CONTROL   = 2'h2;

	// Run control field positions and reset value
	localparam int              CTL_ENABLE    = 7;
	localparam int              CTL_RUN       = 6;
	localparam int              CTL_TAG       = 5;
	localparam int              CTL_BRK_EN    = 4;
	localparam int              CTL_A_DIR     = 3;
	localparam int              CTL_A_CHK     = 2;
	localparam int              CTL_B_DIR     = 1;
	localparam int              CTL_B_CHK     = 0;
	localparam logic [7:0]      CTL_RESET     = 8'h00;

	// Trigger mode codes
	localparam logic [3:0]      TRG_A_ONLY    = 4'h0;
	localparam logic [3:0]      TRG_A_OR_B    = 4'h1;
	localparam logic [3:0]      TRG_A_THEN_B  = 4'h2;
	localparam logic [3:0]      TRG_EVENT_B   = 4'h3;
	localparam logic [3:0]      TRG_A_EVENT_B = 4'h4;
	localparam logic [3:0]      TRG_A_AND_BD  = 4'h5;
	localparam logic [3:0]      TRG_A_NOT_BD  = 4'h6;
	localparam logic [3:0]      TRG_INSIDE    = 4'h7;
	localparam logic [3:0]      TRG_OUTSIDE   = 4'h8;

	localparam logic [3:0]      CNT_FULL      = 4'h8;

	// Host-side APB map
	localparam logic [11:0]     APB_COMMAND   = 12'h000;
	localparam logic [11:0]     APB_RESULT    = 12'h004;
	localparam int              CMD_SEL_LSB   = 0;
	localparam int              CMD_WRITE     = 8;
	localparam int              CMD_DATA_LSB  = 16;
	localparam int              RES_BUSY      = 31;

	typedef logic [FIFO_DEPTH-1:0][WORD_W-1:0] dtf_fifo_t;

endpackage : dtf_pkg

// ===== common/dtf_if.sv
// Register access port between the debug module and the reading party
`timescale 1ns/1ps
`default_nettype none
interface dtf_if;
	logic [1:0] sel;
	logic       rd;
	logic       wr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport dev  (input sel, input rd, input wr, input wdata, output rdata);
	modport host (output sel, output rd, output wr, output wdata, input rdata);
endinterface : dtf_if
`default_nettype wire

// ===== rtl/dtf_device.sv
// Debug module end: trace FIFO readout, run control and trigger capture
// Contract
// - High port returns upper byte; writes ignored
// - Event-only modes: bytes only, high reads zero
// - High read never advances the FIFO
// - Low read returns low byte, then shifts unless a run is armed
// - Reader takes high byte before low byte
// - Event-only: reader repeats low-byte reads
// - Reader avoids FIFO reads during active run
// - Idle low read stores last opcode address
// - Eight words; ninth read returns first sample
// - Profiling host discards first eight reads
// - Control register accessible at any time
// - Enable bit 7; refused while secure
// - Run bit 6 starts run; completion clears
// - Writing zero to run/enable ends run
// - Bit 5 selects tag or force break
// - Bit 4 lets triggers request CPU break
// - Break: trigger in end, full in begin and in event-only modes
// - Break requests leave qualification unchanged
// - Comparator A direction check, bits 3 and 2
// - Comparator B direction check, bits 1 and 0
// - Run ends on full or on trigger
// - Codes 0011 and 0100 are event-only
`timescale 1ns/1ps
`default_nettype none
module dtf_device
	import dtf_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Register port
	dtf_if.dev               bus,
	// Monitored CPU bus
	input  wire logic [15:0] cpu_addr,
	input  wire logic [7:0]  cpu_data,
	input  wire logic        cpu_rw,
	input  wire logic        cpu_valid,
	input  wire logic        cpu_fetch,
	input  wire logic        secure,
	// Comparator and trigger setup
	input  wire logic [15:0] cmp_a,
	input  wire logic [15:0] cmp_b,
	input  wire logic [3:0]  trig_mode,
	input  wire logic        trig_begin,
	input  wire logic        trigger_qualify_select,
	// Status and break
	output logic             break_req,
	output logic             break_tag,
	output logic             run_active_flag,
	output logic             match_a_flag,
	output logic             match_b_flag,
	output logic [3:0]       fifo_count
);
	import dtf_pkg::*;

	typedef struct packed {
		logic [7:0]  ctrl;
		dtf_fifo_t   fifo;
		logic [3:0]  cnt;
		logic [15:0] last_fetch;
		logic        a_seen;
		logic        b_seen;
		logic        started;
		logic [7:0]  rdata;
		logic        brk;
	} dtf_dev_s;

	dtf_dev_s state_reg;
	dtf_dev_s state_next;

	// Push a word into the last location, shifting toward the head
	function automatic dtf_fifo_t push(input dtf_fifo_t f, input logic [15:0] w);
		push = {w, f[FIFO_DEPTH-1:1]};
	endfunction : push

	// Comparator with optional direction qualification
	function automatic logic cmp_hit(input logic [15:0] ref_addr, input logic chk,
			input logic dir);
		cmp_hit = cpu_valid && (cpu_addr == ref_addr) && (!chk || (cpu_rw == dir))
			&& (!trigger_qualify_select || cpu_fetch);
	endfunction : cmp_hit

	logic       armed;
	logic       event_only;
	logic       ma;
	logic       mb;
	logic       trig;
	logic       store;
	logic [15:0] store_word;
	logic [7:0] w;
	logic       en_new;

	always_comb begin
		state_next = state_reg;
		state_next.brk = 1'b0;
		armed = state_reg.ctrl[CTL_ENABLE] && state_reg.ctrl[CTL_RUN];
		event_only = (trig_mode == TRG_EVENT_B) || (trig_mode == TRG_A_EVENT_B);
		ma = cmp_hit(cmp_a, state_reg.ctrl[CTL_A_CHK], state_reg.ctrl[CTL_A_DIR]);
		mb = cmp_hit(cmp_b, state_reg.ctrl[CTL_B_CHK], state_reg.ctrl[CTL_B_DIR]);
		trig = 1'b0;
		store = 1'b0;
		store_word = cpu_addr;
		w = bus.wdata;
		en_new = 1'b0;
		if (cpu_valid && cpu_fetch) begin
			state_next.last_fetch = cpu_addr;
		end
		if (armed) begin
			if (ma) begin
				state_next.a_seen = 1'b1;
			end
			if (mb) begin
				state_next.b_seen = 1'b1;
			end
			unique case (trig_mode)
				TRG_A_ONLY:    trig = ma;
				TRG_A_OR_B:    trig = ma || mb;
				TRG_A_THEN_B:  trig = state_reg.a_seen && mb;
				TRG_EVENT_B:   trig = mb;
				TRG_A_EVENT_B: trig = (state_reg.a_seen || ma) && mb;
				TRG_A_AND_BD:  trig = ma && (cpu_data == cmp_b[7:0]);
				TRG_A_NOT_BD:  trig = ma && (cpu_data != cmp_b[7:0]);
				TRG_INSIDE:    trig = cpu_valid && (cpu_addr >= cmp_a) && (cpu_addr <= cmp_b);
				TRG_OUTSIDE:   trig = cpu_valid && ((cpu_addr < cmp_a) || (cpu_addr > cmp_b));
				default:       trig = 1'b0;
			endcase
			if (event_only) begin
				store = trig;
				store_word = {8'h00, cpu_data};
			end else if (trig_begin) begin
				store = (state_reg.started || trig) && cpu_valid && cpu_fetch;
				if (trig) begin
					state_next.started = 1'b1;
				end
			end else begin
				store = cpu_valid && cpu_fetch;
			end
			if (store) begin
				state_next.fifo = push(state_reg.fifo, store_word);
				if (state_reg.cnt != CNT_FULL) begin
					state_next.cnt = state_reg.cnt + 4'h1;
				end
			end
			// Run completion and break request
			if (!event_only && !trig_begin && trig) begin
				state_next.ctrl[CTL_RUN] = 1'b0;
				state_next.brk = state_reg.ctrl[CTL_BRK_EN];
			end else if ((event_only || trig_begin) && store
					&& (state_reg.cnt == CNT_FULL - 4'h1)) begin
				state_next.ctrl[CTL_RUN] = 1'b0;
				state_next.brk = state_reg.ctrl[CTL_BRK_EN];
			end
		end
		// Register reads are registered: data and FIFO shift appear the cycle after the access
		if (bus.rd) begin
			unique case (bus.sel)
				SEL_FIFO_HIGH: begin
					state_next.rdata = event_only ? 8'h00 : state_reg.fifo[0][15:8];
				end
				SEL_FIFO_LOW: begin
					state_next.rdata = state_reg.fifo[0][7:0];
					if (!armed) begin
						state_next.fifo = push(state_reg.fifo, state_reg.last_fetch);
					end
				end
				SEL_CONTROL: begin
					state_next.rdata = state_reg.ctrl;
				end
				default: begin
					state_next.rdata = 8'h00;
				end
			endcase
		end
		// Only the control register accepts writes
		if (bus.wr && (bus.sel == SEL_CONTROL)) begin
			en_new = w[CTL_ENABLE] && !secure;
			state_next.ctrl = w;
			state_next.ctrl[CTL_ENABLE] = en_new;
			state_next.ctrl[CTL_RUN] = w[CTL_RUN] && en_new;
			if (w[CTL_RUN] && en_new && !armed) begin
				state_next.cnt = 4'h0;
				state_next.a_seen = 1'b0;
				state_next.b_seen = 1'b0;
				state_next.started = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
			state_reg.ctrl <= CTL_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign bus.rdata = state_reg.rdata;
	assign break_req = state_reg.brk;
	assign break_tag = state_reg.ctrl[CTL_TAG];
	assign run_active_flag = state_reg.ctrl[CTL_ENABLE] && state_reg.ctrl[CTL_RUN];
	assign match_a_flag = state_reg.a_seen;
	assign match_b_flag = state_reg.b_seen;
	assign fifo_count = state_reg.cnt;

endmodule : dtf_device
`default_nettype wire

// ===== rtl/dtf_host.sv
// Reading party end: APB command registers driving the debug register port
`timescale 1ns/1ps
`default_nettype none
module dtf_host
	import dtf_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Debug register port
	dtf_if.host              bus
);
	import dtf_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_CAPTURE} dtf_host_e;

	typedef struct packed {
		dtf_host_e  st;
		logic [1:0] sel;
		logic       wr;
		logic [7:0] wdata;
		logic [7:0] result;
	} dtf_host_s;

	dtf_host_s state_reg;
	dtf_host_s state_next;
	logic      access;
	logic      mapped;

	always_comb begin
		state_next = state_reg;
		access = psel && penable;
		mapped = (paddr == APB_COMMAND) || (paddr == APB_RESULT);
		unique case (state_reg.st)
			ST_IDLE: begin
				if (access && pwrite && (paddr == APB_COMMAND)) begin
					state_next.sel = pwdata[CMD_SEL_LSB +: 2];
					state_next.wr = pwdata[CMD_WRITE];
					state_next.wdata = pwdata[CMD_DATA_LSB +: 8];
					state_next.st = ST_ISSUE;
				end
			end
			ST_ISSUE: begin
				state_next.st = ST_CAPTURE;
			end
			ST_CAPTURE: begin
				state_next.result = bus.rdata;
				state_next.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign bus.sel = state_reg.sel;
	assign bus.wdata = state_reg.wdata;
	assign bus.rd = (state_reg.st == ST_ISSUE) && !state_reg.wr;
	assign bus.wr = (state_reg.st == ST_ISSUE) && state_reg.wr;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	always_comb begin
		prdata = 32'h0000_0000;
		if (psel && (paddr == APB_RESULT)) begin
			prdata[7:0] = state_reg.result;
			prdata[RES_BUSY] = (state_reg.st != ST_IDLE);
		end
	end

endmodule : dtf_host
`default_nettype wire

// ===== test/dtf_props.sv
// Assertions on the register port between host and debug module
`timescale 1ns/1ps
`default_nettype none
module dtf_props
	import dtf_pkg::*;
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Register port
	input  wire logic [1:0] sel,
	input  wire logic       rd,
	input  wire logic       wr,
	input  wire logic [7:0] wdata,
	input  wire logic [7:0] rdata
);
	import dtf_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic       hi_pend;
	logic       hi_ok;
	logic [7:0] hi_val;
	// Last high byte seen since the last read or write of another register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_pend <= 1'b0;
			hi_ok   <= 1'b0;
			hi_val  <= 8'h00;
		end else begin
			hi_pend <= rd && sel == SEL_FIFO_HIGH;
			if (hi_pend)
				hi_val <= rdata;
			hi_ok <= hi_pend || (hi_ok && !(wr && sel != SEL_FIFO_HIGH)
				&& !(rd && sel != SEL_FIFO_HIGH));
		end
	end
	a_strobe_exclusive: assert property (!(rd && wr))
		else $error("read and write strobes together");
	a_read_single: assert property (rd |=> !rd)
		else $error("read strobe longer than one cycle");
	a_write_single: assert property (wr |=> !wr)
		else $error("write strobe longer than one cycle");
	a_access_spacing: assert property ((rd || wr) |=> !(rd || wr) [*2])
		else $error("accesses closer than the command round trip");
	a_rdata_holds: assert property (!rd |=> $stable(rdata))
		else $error("read data changed without a read");
	a_write_no_data: assert property (wr |=> $stable(rdata))
		else $error("write disturbed read data");
	a_high_repeat: assert property (hi_pend && hi_ok |-> rdata == hi_val)
		else $error("repeated high read returned another byte");
	a_idle_after_reset: assert property ($rose(presetn) |-> !rd && !wr)
		else $error("strobe active right after reset");
endmodule : dtf_props
`default_nettype wire

// ===== test/debug_trace_fifo_readout_ctrl_tb.sv
// Testbench for the trace FIFO readout and run control pair
`timescale 1ns/1ps
`default_nettype none
module debug_trace_fifo_readout_ctrl_tb;
	import dtf_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        pready, pslverr, break_req, break_tag, run_active_flag;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [15:0] cpu_addr = 16'h0, cmp_a = 16'h0, cmp_b = 16'h0;
	logic [7:0]  cpu_data = 8'h00;
	logic        cpu_rw = 1'b0, cpu_valid = 1'b0, cpu_fetch = 1'b0, secure = 1'b0;
	logic        trig_begin = 1'b0, trigger_qualify_select = 1'b0, match_a, match_b;
	logic [3:0]  trig_mode = TRG_A_ONLY, fifo_count;
	int          fails = 0, total_checks = 0, brk_cnt = 0;
	always #50 pclk = ~pclk;
	dtf_if u_if ();
	dtf_host u_dtf_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus(u_if.host));
	dtf_device u_dtf_device (.pclk(pclk), .presetn(presetn), .bus(u_if.dev),
		.cpu_addr(cpu_addr), .cpu_data(cpu_data), .cpu_rw(cpu_rw), .cpu_valid(cpu_valid),
		.cpu_fetch(cpu_fetch), .secure(secure), .cmp_a(cmp_a), .cmp_b(cmp_b),
		.trig_mode(trig_mode), .trig_begin(trig_begin),
		.trigger_qualify_select(trigger_qualify_select),
		.break_req(break_req), .break_tag(break_tag), .run_active_flag(run_active_flag),
		.match_a_flag(match_a), .match_b_flag(match_b), .fifo_count(fifo_count));
	dtf_props u_dtf_props (.pclk(pclk), .presetn(presetn), .sel(u_if.sel), .rd(u_if.rd),
		.wr(u_if.wr), .wdata(u_if.wdata), .rdata(u_if.rdata));
	always @(posedge pclk)
		if (break_req === 1'b1)
			brk_cnt++;
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_byte
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic dev(input logic [1:0] s, input logic w, input logic [7:0] d,
		output logic [7:0] q8);
		logic [31:0] r;
		logic        e;
		apb(1'b1, APB_COMMAND, (32'(d) << CMD_DATA_LSB) | (32'(w) << CMD_WRITE)
			| (32'(s) << CMD_SEL_LSB), r, e);
		r = 32'h8000_0000;
		while (r[RES_BUSY] !== 1'b0)
			apb(1'b0, APB_RESULT, 32'h0, r, e);
		q8 = r[7:0];
	endtask : dev
	task automatic rdc(input logic [1:0] s, input logic [7:0] exp);
		logic [7:0] v;
		dev(s, 1'b0, 8'h00, v);
		chk_byte(v, exp);
	endtask : rdc
	task automatic wr8(input logic [1:0] s, input logic [7:0] d);
		logic [7:0] v;
		dev(s, 1'b1, d, v);
	endtask : wr8
	task automatic cpu(input logic [15:0] a, input logic rw, input logic [7:0] d,
		input logic v, input logic f, input int n);
		cpu_addr <= a;
		cpu_rw <= rw;
		cpu_data <= d;
		cpu_valid <= v;
		cpu_fetch <= f;
		repeat (n) @(posedge pclk);
	endtask : cpu
	// End trace: first access must leave the run going, second must end it
	task automatic mode_run(input logic [3:0] m, input logic [15:0] a1, input logic [7:0] d1,
		input logic [15:0] a2, input logic [7:0] d2);
		trig_mode <= m;
		wr8(SEL_CONTROL, 8'hc0);
		cpu(a1, 1'b1, d1, 1'b1, 1'b1, 1);
		cpu(a1, 1'b1, d1, 1'b0, 1'b0, 1);
		chk_byte({7'h0, run_active_flag}, 8'h01);
		cpu(a2, 1'b1, d2, 1'b1, 1'b1, 1);
		cpu(a2, 1'b1, d2, 1'b0, 1'b0, 1);
		chk_byte({7'h0, run_active_flag}, 8'h00);
	endtask : mode_run
	initial begin
		#2000000;
		fails++;
		end_of_test();
	end
	initial begin
		logic [7:0]  v;
		logic [15:0] a;
		logic [15:0] ca;
		logic [15:0] cb;
		logic [31:0] r;
		logic        e;
		logic [15:0] q[$];
		void'($urandom(49));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(SEL_CONTROL, CTL_RESET);
		chk_byte({7'h0, run_active_flag}, 8'h00);
		apb(1'b0, 12'h008, 32'h0, r, e);
		chk_byte({7'h0, e}, 8'h01);
		secure <= 1'b1;
		wr8(SEL_CONTROL, 8'h80);
		rdc(SEL_CONTROL, 8'h00);
		secure <= 1'b0;
		v = 8'h80 | 8'($urandom & 32'h3f);
		wr8(SEL_CONTROL, v);
		rdc(SEL_CONTROL, v);
		chk_byte({7'h0, break_tag}, {7'h0, v[CTL_TAG]});
		// End trace on comparator A, reads only
		a = 16'($urandom);
		cmp_a <= a;
		wr8(SEL_CONTROL, 8'hc0);
		chk_byte({7'h0, run_active_flag}, 8'h01);
		wr8(SEL_CONTROL, 8'h80);
		chk_byte({7'h0, run_active_flag}, 8'h00);
		wr8(SEL_CONTROL, 8'hdc);
		cpu(a, 1'b0, 8'h00, 1'b1, 1'b1, 10);
		chk_byte({7'h0, run_active_flag}, 8'h01);
		cpu(a, 1'b1, 8'h00, 1'b1, 1'b1, 4);
		cpu(a, 1'b1, 8'h00, 1'b0, 1'b0, 1);
		chk_byte({7'h0, run_active_flag}, 8'h00);
		chk_byte(8'(brk_cnt), 8'h01);
		chk_byte({7'h0, break_tag}, 8'h00);
		chk_byte({7'h0, match_a}, 8'h01);
		rdc(SEL_CONTROL, 8'h9c);
		// Event-only capture on comparator B, writes only
		a = 16'($urandom);
		cmp_b <= a;
		trig_mode <= TRG_EVENT_B;
		wr8(SEL_CONTROL, 8'hc1);
		cpu(a, 1'b1, 8'h5a, 1'b1, 1'b1, 4);
		chk_byte({4'h0, fifo_count}, 8'h00);
		q.delete();
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			v = 8'($urandom);
			q.push_back({8'h00, v});
			cpu(a, 1'b0, v, 1'b1, 1'b1, 1);
		end
		cpu(a, 1'b0, 8'h00, 1'b0, 1'b0, 2);
		chk_byte({4'h0, fifo_count}, {4'h0, CNT_FULL});
		chk_byte({7'h0, run_active_flag}, 8'h00);
		chk_byte(8'(brk_cnt), 8'h01);
		chk_byte({6'h0, match_a, match_b}, 8'h01);
		// Readout, then profiling samples
		for (int i = 0; i < 12; i++) begin
			if (i == FIFO_DEPTH)
				trig_mode <= TRG_A_ONLY;
			a = 16'($urandom) | 16'h0100;
			cpu(a, 1'b1, 8'h00, 1'b1, 1'b1, 2);
			rdc(SEL_FIFO_HIGH, q[0][15:8]);
			wr8(SEL_FIFO_HIGH, 8'hff);
			rdc(SEL_FIFO_HIGH, q[0][15:8]);
			rdc(SEL_FIFO_LOW, q[0][7:0]);
			wr8(SEL_FIFO_LOW, 8'hff);
			void'(q.pop_front());
			q.push_back(a);
		end
		chk_byte({4'h0, fifo_count}, {4'h0, CNT_FULL});
		// Event-only mode hides the high byte of stored addresses
		trig_mode <= TRG_A_EVENT_B;
		cpu(16'h0000, 1'b0, 8'h00, 1'b0, 1'b0, 1);
		rdc(SEL_FIFO_HIGH, 8'h00);
		// Remaining trigger modes in end trace
		ca = 16'h4000 | 16'($urandom & 32'h0fff);
		cb = ca + 16'h1000;
		cmp_a <= ca;
		cmp_b <= cb;
		mode_run(TRG_A_OR_B, ca + 16'h0001, 8'h00, cb, 8'h00);
		mode_run(TRG_A_THEN_B, ca, 8'h00, cb, 8'h00);
		mode_run(TRG_A_AND_BD, ca, ~cb[7:0], ca, cb[7:0]);
		mode_run(TRG_A_NOT_BD, ca, cb[7:0], ca, ~cb[7:0]);
		mode_run(TRG_INSIDE, cb + 16'h0001, 8'h00, ca + 16'h0001, 8'h00);
		mode_run(TRG_OUTSIDE, ca + 16'h0001, 8'h00, cb + 16'h0001, 8'h00);
		// Begin trace on qualified comparator A, break when full
		a = 16'($urandom);
		cmp_a <= a;
		trig_mode <= TRG_A_ONLY;
		trig_begin <= 1'b1;
		trigger_qualify_select <= 1'b1;
		wr8(SEL_CONTROL, 8'hf0);
		cpu(a, 1'b1, 8'h00, 1'b1, 1'b0, 3);
		chk_byte({6'h0, match_a, run_active_flag}, 8'h01);
		chk_byte({4'h0, fifo_count}, 8'h00);
		cpu(a, 1'b1, 8'h00, 1'b1, 1'b1, 1);
		cpu(~a, 1'b1, 8'h00, 1'b1, 1'b1, FIFO_DEPTH - 2);
		chk_byte(8'(brk_cnt), 8'h01);
		cpu(~a, 1'b1, 8'h00, 1'b1, 1'b1, 1);
		cpu(~a, 1'b1, 8'h00, 1'b0, 1'b0, 2);
		chk_byte(8'(brk_cnt), 8'h02);
		chk_byte({6'h0, break_tag, run_active_flag}, 8'h02);
		chk_byte({4'h0, fifo_count}, {4'h0, CNT_FULL});
		rdc(SEL_FIFO_HIGH, a[15:8]);
		rdc(SEL_FIFO_LOW, a[7:0]);
		// Reset in the middle of a run
		trig_begin <= 1'b0;
		trigger_qualify_select <= 1'b0;
		wr8(SEL_CONTROL, 8'hc0);
		cpu(~a, 1'b1, 8'h00, 1'b1, 1'b1, 3);
		chk_byte({7'h0, run_active_flag}, 8'h01);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk_byte({4'h0, fifo_count}, 8'h00);
		rdc(SEL_CONTROL, CTL_RESET);
		chk_byte({7'h0, run_active_flag}, 8'h00);
		end_of_test();
	end
endmodule : debug_trace_fifo_readout_ctrl_tb
`default_nettype wire
